// ---- rtl/smep_port.sv ----
`timescale 1ns/1ps

// Summary of operation
// - master or slave; four-wire with select or three-wire without select
// - mode fault and receive overrun are detected and reported as errors
// - serial clock idle polarity and per-command clock phase are selectable
// - each frame shifts msb first or lsb first by a bit-order setting
// - frame length 8 to 16 bits, or 20, 24 or 32 bits
// - double-buffered four-word transmit and receive stores, up to four frames
// - four select outputs, each with its own active polarity
// - lead, trail and next-access delays of 1 to 8 serial clock periods
// - master runs up to four command entries in sequence, optionally looping
// - master holds data-out at a fixed level while select is negated
// - maskable requests: receive full, transmit empty, fault or overrun
// - loopback, push-pull or open-drain driver, disable returns to reset state

module smep_port #(
	parameter logic [7:0] SCK_HALF = 8'(smep_pkg::SCK_HALF_CYCLES)
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        link_clk,
	input  wire logic        enable,
	input  wire logic        master,
	input  wire logic        three_wire,
	input  wire logic        cpol,
	input  wire logic        lsb_first,
	input  wire logic        loopback,
	input  wire logic        open_drain,
	input  wire logic        modf_en,
	input  wire logic        mosi_idle,
	input  wire logic [1:0]  seq_len,
	input  wire logic        loop_seq,
	input  wire logic [15:0] cmd_len,
	input  wire logic [3:0]  cmd_cpha,
	input  wire logic [3:0]  cmd_keep,
	input  wire logic [7:0]  cmd_ssl,
	input  wire logic [3:0]  ssl_pol,
	input  wire logic [2:0]  clk_delay,
	input  wire logic [2:0]  neg_delay,
	input  wire logic [2:0]  next_delay,
	input  wire logic        rx_ie,
	input  wire logic        tx_ie,
	input  wire logic        err_ie,
	input  wire logic        tx_wr,
	input  wire logic [1:0]  tx_wr_idx,
	input  wire logic [31:0] tx_wr_data,
	input  wire logic        tx_commit,
	input  wire logic [1:0]  rx_rd_idx,
	output logic [31:0]      rx_rd_data,
	input  wire logic        rx_ack,
	input  wire logic        err_clear,
	input  wire logic        miso_in,
	input  wire logic        ssl_in,
	input  wire logic        mosi_in,
	output logic             sck_out,
	output logic             sck_oe,
	output logic             mosi_out,
	output logic             mosi_oe,
	output logic [3:0]       ssl_out,
	output logic             ssl_oe,
	output logic             busy,
	output logic             tx_empty,
	output logic             rx_full,
	output logic             overrun,
	output logic             mode_fault,
	output logic             irq_rx,
	output logic             irq_tx,
	output logic             irq_err
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		smep_pkg::smep_state_type state;
		logic [7:0]               cnt;
		logic [6:0]               hcnt;
		logic [1:0]               cmd;
		logic [1:0]               sel;
		logic                     last;
		logic [31:0]              sh;
		logic [31:0]              rsh;
		logic                     ssl_act;
		logic                     sck;
		logic                     mosi_bit;
		logic                     mosi_o;
		logic                     mosi_oe;
		logic                     sck_oe;
		logic [3:0]               slave_select_line;
		logic                     ssl_oe;
		logic                     tx_full;
		logic                     tx_empty;
		logic                     rx_full;
		logic                     ovr;
		logic                     modf;
		logic [1:0]               sfr;
		logic                     ssl_s1;
		logic                     ssl_s2;
		logic                     miso_s1;
		logic                     miso_s2;
		logic                     tog_s1;
		logic                     tog_s2;
		logic                     tog_s3;
		logic                     irq_rx;
		logic                     irq_tx;
		logic                     irq_err;
		logic                     busy;
	} smep_core_type;

	typedef struct packed {
		logic        rs1;
		logic        rs2;
		logic [5:0]  bcnt;
		logic [31:0] rsh;
		logic [31:0] hold;
		logic        tog;
	} smep_link_type;

	smep_core_type st;
	smep_core_type next_st;
	smep_link_type lk;
	smep_link_type next_lk;

	logic [31:0] tx_rd;
	logic        rx_we;
	logic [1:0]  rx_wa;
	logic [31:0] rx_wd;
	logic [3:0]  ssl_nx;
	logic        tick;
	logic [5:0]  cur_len;
	logic [5:0]  slv_len;
	logic        cur_cpha;
	logic        cur_keep;
	logic        rx_bit;

	assign tick     = (st.cnt >= SCK_HALF - 8'h01);
	assign cur_len  = smep_pkg::frame_bits(cmd_len[{st.cmd, 2'b00} +: 4]);
	assign slv_len  = smep_pkg::frame_bits(cmd_len[3:0]);
	assign cur_cpha = cmd_cpha[st.cmd];
	assign cur_keep = cmd_keep[st.cmd];
	assign rx_bit   = loopback ? st.mosi_bit : st.miso_s2;

	// ------------------------------------------------------------
	// transmit and receive stores
	// ------------------------------------------------------------
	smep_buf #(.W(smep_pkg::WORD_W), .D(smep_pkg::FRAMES), .AW(smep_pkg::FRAME_AW)) u_tx_buf (
		.clk     (clk),
		.wr_en   (tx_wr),
		.wr_addr (tx_wr_idx),
		.wr_data (tx_wr_data),
		.rd_addr (st.cmd),
		.rd_data (tx_rd)
	);

	smep_buf #(.W(smep_pkg::WORD_W), .D(smep_pkg::FRAMES), .AW(smep_pkg::FRAME_AW)) u_rx_buf (
		.clk     (clk),
		.wr_en   (rx_we),
		.wr_addr (rx_wa),
		.wr_data (rx_wd),
		.rd_addr (rx_rd_idx),
		.rd_data (rx_rd_data)
	);

	// ------------------------------------------------------------
	// select drive per output
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_ssl
			assign ssl_nx[gi] = (st.ssl_act && !three_wire && st.sel == 2'(gi)) ? ssl_pol[gi] : ~ssl_pol[gi];
		end
	endgenerate

	// ------------------------------------------------------------
	// core engine
	// ------------------------------------------------------------
	always_comb begin
		logic do_load;
		logic framing;
		logic obit;
		do_load   = 1'b0;
		framing   = 1'b0;
		obit      = 1'b0;
		next_st   = st;
		rx_we     = 1'b0;
		rx_wa     = st.cmd;
		rx_wd     = smep_pkg::word_justify(st.rsh, cur_len, lsb_first);
		next_st.ssl_s1  = ssl_in;
		next_st.ssl_s2  = st.ssl_s1;
		next_st.miso_s1 = miso_in;
		next_st.miso_s2 = st.miso_s1;
		next_st.tog_s1  = lk.tog;
		next_st.tog_s2  = st.tog_s1;
		next_st.tog_s3  = st.tog_s2;
		next_st.cnt     = tick ? 8'h00 : st.cnt + 8'h01;
		if (rx_ack)
			next_st.rx_full = 1'b0;
		if (err_clear) begin
			next_st.ovr  = 1'b0;
			next_st.modf = 1'b0;
		end
		case (st.state)
			smep_pkg::ST_IDLE: begin
				next_st.cmd = 2'b00;
				if (enable && master && st.tx_full && !st.modf)
					do_load = 1'b1;
			end
			smep_pkg::ST_LEAD: begin
				if (tick) begin
					next_st.hcnt = st.hcnt + 7'h01;
					if (st.hcnt == {3'b000, clk_delay, 1'b0}) begin
						next_st.state = smep_pkg::ST_SHIFT;
						next_st.hcnt  = 7'h00;
					end
				end
			end
			smep_pkg::ST_SHIFT: begin
				if (tick) begin
					next_st.sck  = ~st.sck;
					next_st.hcnt = st.hcnt + 7'h01;
					if (st.hcnt[0] == cur_cpha)
						next_st.rsh = lsb_first ? {rx_bit, st.rsh[31:1]} : {st.rsh[30:0], rx_bit};
					if (st.hcnt[0] != cur_cpha && st.hcnt != 7'h00 && st.hcnt != {cur_len, 1'b0} - 7'h01)
						next_st.sh = lsb_first ? (st.sh >> 1) : (st.sh << 1);
					if (st.hcnt == {cur_len, 1'b0} - 7'h01) begin
						rx_wd = smep_pkg::word_justify(next_st.rsh, cur_len, lsb_first);
						if (st.rx_full)
							next_st.ovr = 1'b1;
						else begin
							rx_we = 1'b1;
							if (st.cmd == seq_len)
								next_st.rx_full = 1'b1;
						end
						next_st.last  = (st.cmd == seq_len);
						next_st.cmd   = (st.cmd == seq_len) ? 2'b00 : st.cmd + 2'b01;
						next_st.hcnt  = 7'h00;
						next_st.state = cur_keep ? smep_pkg::ST_GAP : smep_pkg::ST_TRAIL;
					end
				end
			end
			smep_pkg::ST_TRAIL: begin
				if (tick) begin
					next_st.hcnt = st.hcnt + 7'h01;
					if (st.hcnt == {3'b000, neg_delay, 1'b1}) begin
						next_st.ssl_act = 1'b0;
						next_st.state   = smep_pkg::ST_GAP;
						next_st.hcnt    = 7'h00;
					end
				end
			end
			smep_pkg::ST_GAP: begin
				if (tick) begin
					next_st.hcnt = st.hcnt + 7'h01;
					if (st.hcnt == {3'b000, next_delay, 1'b1}) begin
						next_st.state = smep_pkg::ST_GAPX;
						next_st.cnt   = 8'h00;
					end
				end
			end
			smep_pkg::ST_GAPX: begin
				if (st.cnt == 8'(smep_pkg::GAP_EXTRA_CYCLES - 1)) begin
					next_st.cnt = 8'h00;
					if (!st.last || (loop_seq && st.tx_full))
						do_load = 1'b1;
					else
						next_st.state = smep_pkg::ST_IDLE;
				end
			end
			default: begin
				next_st.state = smep_pkg::ST_IDLE;
			end
		endcase
		if (do_load) begin
			next_st.state   = smep_pkg::ST_LEAD;
			next_st.hcnt    = 7'h00;
			next_st.cnt     = 8'h00;
			next_st.ssl_act = !three_wire;
			next_st.sel     = cmd_ssl[{st.cmd, 1'b0} +: 2];
			next_st.rsh     = 32'h00000000;
			next_st.sh      = lsb_first ? tx_rd : (tx_rd << (smep_pkg::LEN_32 - cur_len));
			if (st.cmd == seq_len)
				next_st.tx_full = 1'b0;
		end
		if (tx_commit)
			next_st.tx_full = 1'b1;
		if (!master && enable && st.tog_s3 != st.tog_s2) begin
			rx_wa = st.sfr;
			rx_wd = lk.hold;
			if (st.rx_full)
				next_st.ovr = 1'b1;
			else begin
				rx_we       = 1'b1;
				next_st.sfr = (st.sfr == seq_len) ? 2'b00 : st.sfr + 2'b01;
				if (st.sfr == seq_len)
					next_st.rx_full = 1'b1;
			end
		end
		if (enable && master && !three_wire && modf_en && st.ssl_s2 == ssl_pol[0]) begin
			next_st.modf    = 1'b1;
			next_st.state   = smep_pkg::ST_IDLE;
			next_st.ssl_act = 1'b0;
		end
		if (!enable) begin
			next_st.state   = smep_pkg::ST_IDLE;
			next_st.cmd     = 2'b00;
			next_st.sfr     = 2'b00;
			next_st.ssl_act = 1'b0;
			next_st.tx_full = 1'b0;
			next_st.rx_full = 1'b0;
			next_st.ovr     = 1'b0;
			next_st.modf    = 1'b0;
		end
		if (next_st.state != smep_pkg::ST_SHIFT)
			next_st.sck = cpol;
		framing = three_wire ? (next_st.state == smep_pkg::ST_LEAD || next_st.state == smep_pkg::ST_SHIFT)
			: next_st.ssl_act;
		obit = framing ? (lsb_first ? next_st.sh[0] : next_st.sh[31]) : mosi_idle;
		next_st.mosi_bit = obit;
		next_st.mosi_o   = open_drain ? 1'b0 : obit;
		next_st.mosi_oe  = enable && master && (open_drain ? !obit : 1'b1);
		next_st.sck_oe   = enable && master;
		next_st.ssl_oe   = enable && master && !three_wire;
		next_st.slave_select_line      = ssl_nx;
		next_st.tx_empty = !next_st.tx_full;
		next_st.busy     = (next_st.state != smep_pkg::ST_IDLE);
		next_st.irq_rx   = next_st.rx_full && rx_ie;
		next_st.irq_tx   = enable && !next_st.tx_full && tx_ie;
		next_st.irq_err  = (next_st.ovr || next_st.modf) && err_ie;
	end

	always_ff @(posedge clk) begin
		if (!resetn)
			st <= '0;
		else
			st <= next_st;
	end

	// ------------------------------------------------------------
	// slave receiver on the link clock
	// ------------------------------------------------------------
	always_comb begin
		logic [31:0] r;
		r       = lsb_first ? {mosi_in, lk.rsh[31:1]} : {lk.rsh[30:0], mosi_in};
		next_lk = lk;
		next_lk.rs1 = resetn;
		next_lk.rs2 = lk.rs1;
		if (!lk.rs2) begin
			next_lk.bcnt = 6'h00;
			next_lk.rsh  = 32'h00000000;
			next_lk.hold = 32'h00000000;
			next_lk.tog  = 1'b0;
		end else if (!master && enable && (three_wire || ssl_in == ssl_pol[0])) begin
			next_lk.rsh  = r;
			next_lk.bcnt = lk.bcnt + 6'h01;
			if (lk.bcnt == slv_len - 6'h01) begin
				next_lk.hold = smep_pkg::word_justify(r, slv_len, lsb_first);
				next_lk.tog  = ~lk.tog;
				next_lk.bcnt = 6'h00;
			end
		end else
			next_lk.bcnt = 6'h00;
	end

	always_ff @(posedge link_clk) begin
		lk <= next_lk;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign sck_out    = st.sck;
	assign sck_oe     = st.sck_oe;
	assign mosi_out   = st.mosi_o;
	assign mosi_oe    = st.mosi_oe;
	assign ssl_out    = st.slave_select_line;
	assign ssl_oe     = st.ssl_oe;
	assign busy       = st.busy;
	assign tx_empty   = st.tx_empty;
	assign rx_full    = st.rx_full;
	assign overrun    = st.ovr;
	assign mode_fault = st.modf;
	assign irq_rx     = st.irq_rx;
	assign irq_tx     = st.irq_tx;
	assign irq_err    = st.irq_err;

endmodule

// ---- pkg/smep_pkg.sv ----
package smep_pkg;

	// ------------------------------------------------------------
	// clocking and timing
	// ------------------------------------------------------------
	localparam int CLK_HZ            = 200_000_000;
	localparam int SCK_HZ            = 2_000_000;
	localparam int SCK_HALF_CYCLES   = CLK_HZ / (2 * SCK_HZ);
	localparam int GAP_EXTRA_CYCLES  = 2;

	// ------------------------------------------------------------
	// data path geometry
	// ------------------------------------------------------------
	localparam int WORD_W            = 32;
	localparam int FRAMES            = 4;
	localparam int FRAME_AW          = 2;

	// ------------------------------------------------------------
	// frame length codes
	// ------------------------------------------------------------
	localparam logic [3:0] LEN_CODE_20 = 4'h9;
	localparam logic [3:0] LEN_CODE_24 = 4'hA;
	localparam logic [5:0] LEN_BASE    = 6'h08;
	localparam logic [5:0] LEN_20      = 6'h14;
	localparam logic [5:0] LEN_24      = 6'h18;
	localparam logic [5:0] LEN_32      = 6'h20;

	// ------------------------------------------------------------
	// serial eeprom opcodes, 9-bit frames
	// ------------------------------------------------------------
	localparam logic [8:0] EEPROM_WRITE_ENABLE_OP  = 9'h130;
	localparam logic [8:0] EEPROM_WRITE_DISABLE_OP = 9'h100;
	localparam logic [8:0] EEPROM_CHIP_ERASE_OP    = 9'h120;
	localparam logic [8:0] EEPROM_READ_OP          = 9'h180;
	localparam logic [8:0] EEPROM_WRITE_OP         = 9'h140;
	localparam int         EEPROM_ADDR_BITS        = 6;

	// ------------------------------------------------------------
	// engine states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_LEAD,
		ST_SHIFT,
		ST_TRAIL,
		ST_GAP,
		ST_GAPX
	} smep_state_type;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [5:0] frame_bits(input logic [3:0] code);
		logic [5:0] len;
		len = LEN_32;
		if (code == LEN_CODE_20)
			len = LEN_20;
		else if (code == LEN_CODE_24)
			len = LEN_24;
		else if (code <= 4'h8)
			len = LEN_BASE + {2'b00, code};
		return len;
	endfunction

	function automatic logic [31:0] word_justify(input logic [31:0] r, input logic [5:0] len, input logic lsb);
		logic [31:0] w;
		w = lsb ? (r >> (LEN_32 - len)) : (r & ~(32'hFFFFFFFF << len));
		return w;
	endfunction

endpackage

// ---- rtl/smep_buf.sv ----
`timescale 1ns/1ps

module smep_buf #(
	parameter int W  = 32,
	parameter int D  = 4,
	parameter int AW = 2
) (
	input  wire logic          clk,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [W-1:0]  wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic [W-1:0]       rd_data
);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [W-1:0]        rd;
	} smep_buf_type;

	smep_buf_type st;
	smep_buf_type next_st;

	// ------------------------------------------------------------
	// storage with registered read
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.rd = st.mem[rd_addr];
		if (wr_en)
			next_st.mem[wr_addr] = wr_data;
	end

	always_ff @(posedge clk) begin
		st <= next_st;
	end

	assign rd_data = st.rd;

endmodule

// ---- verif/smep_port_assertions.sv ----
`timescale 1ns/1ps

module smep_port_assertions #(
	parameter logic [7:0] SCK_HALF = 8'(smep_pkg::SCK_HALF_CYCLES)
) (
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic       enable,
	input wire logic       master,
	input wire logic       cpol,
	input wire logic       mosi_idle,
	input wire logic       tx_commit,
	input wire logic       rx_ie,
	input wire logic       err_ie,
	input wire logic [2:0] clk_delay,
	input wire logic [3:0] ssl_pol,
	input wire logic       sck_out,
	input wire logic       mosi_out,
	input wire logic [3:0] ssl_out,
	input wire logic       busy,
	input wire logic       tx_empty,
	input wire logic       rx_full,
	input wire logic       overrun,
	input wire logic       mode_fault,
	input wire logic       irq_rx,
	input wire logic       irq_err
);
	localparam int LEAD_LO = 2 * SCK_HALF - 3;
	localparam int LEAD_HI = 2 * SCK_HALF + 2;
	logic [7:0] half_cnt;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// --------
	// cycles the serial clock has held its level
	// --------
	always_ff @(posedge clk) begin
		if (!resetn || sck_out != $past(sck_out))
			half_cnt <= 8'h00;
		else
			half_cnt <= half_cnt + 8'h01;
	end

	a_sck_idle: assert property (!busy && $past(!busy) |-> sck_out == cpol) else $error("clock not idle");
	a_idle_mosi: assert property (master && enable && !busy && $past(!busy) |-> mosi_out == mosi_idle)
		else $error("data out not at idle level");
	a_half_period: assert property ($fell(sck_out) && busy |-> half_cnt == SCK_HALF - 8'h01)
		else $error("clock half period wrong");
	a_lead_delay: assert property ($rose(ssl_out[0] == ssl_pol[0]) && clk_delay == 3'h0
		|-> ##[LEAD_LO:LEAD_HI] $changed(sck_out)) else $error("lead delay wrong");
	a_commit_start: assert property (tx_commit && enable && master && !busy && !mode_fault && tx_empty
		|-> ##[1:4] busy) else $error("operation not started");
	a_overrun_cause: assert property ($rose(overrun) |-> $past(rx_full)) else $error("overrun without full store");
	a_fault_stop: assert property ($rose(mode_fault) |-> ##[0:4] (ssl_out[0] != ssl_pol[0] && !busy))
		else $error("fault did not stop engine");
	a_err_irq: assert property (err_ie && $past(err_ie) && (overrun || mode_fault)
		&& $past(overrun || mode_fault) |-> irq_err) else $error("error request missing");
	a_rx_irq: assert property (rx_ie && rx_full && $past(rx_ie && rx_full) |-> irq_rx) else $error("rx request missing");
	a_irq_off: assert property (!(rx_ie || err_ie) && $past(!(rx_ie || err_ie))
		|-> !irq_rx && !irq_err) else $error("masked request raised");
	a_disable: assert property ($fell(enable) |=> !busy && !rx_full && !overrun && !mode_fault)
		else $error("disable left state");
	a_spare_sel: assert property ($past(resetn) && enable && $past(enable)
		|-> ssl_out[3:1] == ~ssl_pol[3:1]) else $error("spare select asserted");

	c_full: cover property ($rose(rx_full));
	c_overrun: cover property ($rose(overrun));
	c_fault: cover property ($rose(mode_fault));
endmodule

bind smep_port smep_port_assertions #(.SCK_HALF(SCK_HALF)) i_smep_port_assertions (
	.clk, .resetn, .enable, .master, .cpol, .mosi_idle, .tx_commit, .rx_ie, .err_ie, .clk_delay, .ssl_pol,
	.sck_out, .mosi_out, .ssl_out, .busy, .tx_empty, .rx_full, .overrun, .mode_fault, .irq_rx, .irq_err
);

// ---- verif/smep_eeprom_model.sv ----
`timescale 1ns/1ps

module smep_eeprom_model (
	input  wire logic        sck,
	input  wire logic        mosi,
	input  wire logic        sel,
	input  wire logic [63:0] pattern,
	output logic             miso,
	output logic [31:0]      word,
	output logic [7:0]       nbits,
	output logic [7:0]       sel_rises
);
	logic [5:0] idx = 6'h00;

	initial begin
		miso = 1'b0;
		sel_rises = 8'h00;
	end
	// --------
	// select active high starts a new access
	// --------
	always @(posedge sel) begin
		word <= 32'h0;
		nbits <= 8'h00;
		idx <= 6'h00;
		sel_rises <= sel_rises + 8'h01;
	end
	// capture msb first on rising edges, readback bit changes on rising edges
	always @(posedge sck) begin
		if (sel) begin
			word <= {word[30:0], mosi};
			nbits <= nbits + 8'h01;
			miso <= pattern[~idx];
			idx <= idx + 6'h01;
		end
	end
	// released data line shows the inverse of the last bit
	always @(negedge sel) miso <= ~miso;
endmodule

// ---- verif/smep_port_tb.sv ----
`timescale 1ns/1ps

`define CHK(n, g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("ERROR %s exp %0h got %0h", n, e, g); end end

module smep_port_tb;
	typedef struct packed {
		logic [31:0] d;
		logic [3:0]  c;
		logic        l;
		logic [7:0]  nb;
		logic [31:0] e;
	} smep_row_type;
	localparam smep_row_type ROWS [9] = '{
		'{32'h0000_0130, 4'h1, 1'b0, 8'h09, 32'h0000_0130}, '{32'h0000_0100, 4'h1, 1'b0, 8'h09, 32'h0000_0100},
		'{32'h0000_0120, 4'h1, 1'b0, 8'h09, 32'h0000_0120}, '{32'h0000_01BF, 4'h1, 1'b0, 8'h09, 32'h0000_01BF},
		'{32'h0000_0155, 4'h1, 1'b0, 8'h09, 32'h0000_0155}, '{32'h0000_0130, 4'h1, 1'b1, 8'h09, 32'h0000_0019},
		'{32'h000A_5A5A, 4'h9, 1'b0, 8'h14, 32'h000A_5A5A}, '{32'h8000_0001, 4'hF, 1'b0, 8'h20, 32'h8000_0001},
		'{32'h0000_00C3, 4'h0, 1'b0, 8'h08, 32'h0000_00C3}
	};
	localparam logic [7:0] SLV = 8'h96;
	logic        clk, resetn, link_clk, lk_run, enable, master, three_wire, cpol, lsb_first, loopback;
	logic        open_drain, modf_en, mosi_idle, loop_seq, tx_wr, tx_commit, rx_ack, err_clear, miso_in;
	logic        ssl_in, mosi_in, rx_ie, tx_ie, err_ie, sck_out, sck_oe, mosi_out, mosi_oe, ssl_oe, busy;
	logic        tx_empty, rx_full, overrun, mode_fault, irq_rx, irq_tx, irq_err;
	logic [1:0]  seq_len, tx_wr_idx, rx_rd_idx;
	logic [2:0]  clk_delay, neg_delay, next_delay;
	logic [3:0]  cmd_cpha, cmd_keep, ssl_pol, ssl_out;
	logic [7:0]  cmd_ssl, m_bits, m_rises, r0;
	logic [15:0] cmd_len;
	logic [31:0] tx_wr_data, rx_rd_data, m_word;
	logic [31:0] txw [4];
	logic [63:0] pattern;
	int          err_count = 0;
	int          total_checks = 0;
	int          cycles = 0;
	int          i;

	smep_port #(.SCK_HALF(8'h04)) i_smep_port (
		.clk, .resetn, .link_clk, .enable, .master, .three_wire, .cpol, .lsb_first, .loopback, .open_drain,
		.modf_en, .mosi_idle, .seq_len, .loop_seq, .cmd_len, .cmd_cpha, .cmd_keep, .cmd_ssl, .ssl_pol, .clk_delay,
		.neg_delay, .next_delay, .rx_ie, .tx_ie, .err_ie, .tx_wr, .tx_wr_idx, .tx_wr_data, .tx_commit, .rx_rd_idx,
		.rx_rd_data, .rx_ack, .err_clear, .miso_in, .ssl_in, .mosi_in, .sck_out, .sck_oe, .mosi_out, .mosi_oe,
		.ssl_out, .ssl_oe, .busy, .tx_empty, .rx_full, .overrun, .mode_fault, .irq_rx, .irq_tx, .irq_err
	);
	smep_eeprom_model i_smep_eeprom_model (.sck(sck_out), .mosi(mosi_out), .sel(ssl_out[0]), .pattern,
		.miso(miso_in), .word(m_word), .nbits(m_bits), .sel_rises(m_rises));

	// --------
	// clocks, timeout, helpers
	// --------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		link_clk = 1'b0;
		forever begin
			#62.5;
			if (lk_run || link_clk) link_clk = ~link_clk;
		end
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic note(input string s);
		$display("test %s done", s);
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic ack();
		rx_ack = 1'b1;
		err_clear = 1'b1;
		tick(1);
		rx_ack = 1'b0;
		err_clear = 1'b0;
		tick(2);
	endtask
	task automatic run(input logic [1:0] n, input logic [15:0] ln, input logic [3:0] ph, input logic [3:0] kp);
		int k;
		int t;
		{seq_len, cmd_len, cmd_cpha, cmd_keep} = {n, ln, ph, kp};
		for (k = 0; k <= int'(n); k++) begin
			tick(1);
			{tx_wr, tx_wr_idx, tx_wr_data} = {1'b1, 2'(k), txw[k]};
		end
		tick(1);
		{tx_wr, tx_commit} = 2'h1;
		tick(1);
		tx_commit = 1'b0;
		for (t = 0; t < 50 && busy !== 1'b1; t++) tick(1);
		for (t = 0; t < 3000 && busy !== 1'b0; t++) tick(1);
		tick(2);
	endtask

	// --------
	// main sequence
	// --------
	initial begin
		{resetn, three_wire, cpol, lsb_first, loopback, open_drain, modf_en, mosi_idle, loop_seq} = 9'h000;
		{tx_wr, tx_commit, rx_ack, err_clear, ssl_in, mosi_in, rx_ie, tx_ie, err_ie} = 9'h000;
		{enable, master, lk_run, ssl_pol} = 7'h71;
		{seq_len, tx_wr_idx, rx_rd_idx, clk_delay, neg_delay, next_delay} = 15'h0000;
		{cmd_len, cmd_cpha, cmd_keep, cmd_ssl, tx_wr_data, pattern} = 128'h0;
		repeat (4) @(negedge link_clk);
		resetn = 1'b1;
		// link side needs edges after release to leave reset
		repeat (3) @(negedge link_clk);
		lk_run = 1'b0;
		tick(2);
		`CHK("reset select", ssl_out, ~ssl_pol)
		`CHK("reset pins", {sck_oe, mosi_oe, ssl_oe, irq_tx}, 4'hE)
		`CHK("reset flags", {sck_out, busy, tx_empty, rx_full, overrun}, 5'h04)
		note("reset");
		for (i = 0; i < 9; i++) begin
			lsb_first = ROWS[i].l;
			txw[0] = ROWS[i].d;
			run(2'h0, {12'h000, ROWS[i].c}, 4'h0, 4'h0);
			`CHK("frame bits", m_word, ROWS[i].e)
			`CHK("frame length", m_bits, ROWS[i].nb)
			`CHK("tx empty", tx_empty, 1'b1)
			ack();
		end
		note("frames");
		{lsb_first, txw[0], txw[1], txw[2], txw[3]} = 129'h0;
		pattern = 64'hA5C3_0F1E_7B2D_9648;
		r0 = m_rises;
		run(2'h3, 16'h8888, 4'hF, 4'h7);
		`CHK("read select", 8'(m_rises - r0), 8'h01)
		`CHK("read length", {rx_full, m_bits}, 9'h140)
		for (i = 0; i < 4; i++) begin
			rx_rd_idx = 2'(i);
			tick(2);
			`CHK("read word", rx_rd_data, {16'h0000, pattern[63 - 16 * i -: 16]})
		end
		note("read");
		{rx_ie, err_ie, rx_rd_idx} = 4'hC;
		pattern = ~pattern;
		run(2'h0, 16'h0008, 4'h1, 4'h0);
		`CHK("overrun", {overrun, irq_err, irq_rx}, 3'h7)
		`CHK("kept word", rx_rd_data, {16'h0000, ~pattern[63:48]})
		ack();
		`CHK("cleared", {overrun, rx_full, irq_err, irq_rx}, 4'h0)
		note("overrun");
		{loopback, txw[0]} = {1'b1, 32'h0000_0155};
		run(2'h0, 16'h0001, 4'h0, 4'h0);
		`CHK("loopback", rx_rd_data, 32'h0000_0155)
		loopback = 1'b0;
		ack();
		note("loopback");
		{modf_en, txw[0]} = {1'b1, 32'h0000_ABCD};
		fork
			run(2'h0, 16'h0008, 4'h0, 4'h0);
			begin
				tick(30);
				ssl_in = 1'b1;
			end
		join
		`CHK("mode fault", {mode_fault, irq_err, busy, rx_full, ssl_out[0]}, 5'h18)
		{enable, ssl_in, modf_en} = 3'h0;
		tick(3);
		`CHK("disabled", {mode_fault, busy, rx_full, tx_empty}, 4'h1)
		{enable, tx_ie, three_wire, open_drain} = 4'hF;
		tick(3);
		`CHK("enabled", {tx_empty, irq_tx}, 2'h3)
		`CHK("three wire pins", {mosi_oe, ssl_oe, ssl_out}, 6'h2E)
		{three_wire, open_drain} = 2'h0;
		note("fault");
		{master, ssl_in, cmd_len, mosi_in} = {2'h1, 16'h0000, SLV[7]};
		tick(3);
		lk_run = 1'b1;
		for (i = 6; i >= 0; i--) begin
			@(negedge link_clk);
			mosi_in = SLV[i];
		end
		@(negedge link_clk);
		lk_run = 1'b0;
		tick(12);
		`CHK("slave word", {rx_full, rx_rd_data}, {1'b1, 32'h0000_0096})
		`CHK("slave pins", {sck_oe, mosi_oe, ssl_oe}, 3'h0)
		note("slave");
		close_out();
	end
endmodule
